/* File: design/tht_map.vh */
// Register map, field values and timing constants of the temperature history readout
`ifndef THT_MAP_VH
`define THT_MAP_VH

// APB register byte offsets
`define THT_OFS_CMD 8'h00
`define THT_OFS_STATUS 8'h04
`define THT_OFS_TASKFILE 8'h08
`define THT_OFS_DATA 8'h0c
`define THT_OFS_CTRL 8'h10
`define THT_OFS_INTERVAL 8'h14
`define THT_OFS_PERIOD 8'h18
`define THT_OFS_INDEX 8'h1c

// Command codes accepted in the command register
`define THT_CMD_KEY_OUT 8'h3f
`define THT_CMD_TABLE_IN 8'h2f

// Key sector contents
`define THT_ACTION_TABLE 16'h0005
`define THT_FUNC_READ 16'h0001
`define THT_TID_INVALID 16'h0000
`define THT_TID_TEMP_HIST 16'h0002

// Task file answers
`define THT_ERR_NONE 8'h00
`define THT_ERR_ABORT 8'h04
`define THT_XFER_LO 8'h01
`define THT_XFER_HI 8'h00
`define THT_STS_OK 8'h50

// Status register bit positions
`define THT_STS_BSY 7
`define THT_STS_RDY 6
`define THT_STS_DSC 4
`define THT_STS_DRQ 3
`define THT_STS_ERR 0

// Table layout
`define THT_FMT_VERSION 16'h0002
`define THT_QUEUE_LEN 16'h0080
`define THT_QUEUE_BASE 9'd34
`define THT_QUEUE_END 9'd161
`define THT_GAP_MARK 8'h80
`define THT_LAST_WORD 8'hff

// Reset values
`define THT_INTERVAL_RST 16'h0001
`define THT_PERIOD_RST 16'h0001

// Timing
`define THT_CLK_NS 40'd10
`define THT_MINUTE_NS 40'd60000000000
`define THT_MINUTE_CYCLES (`THT_MINUTE_NS / `THT_CLK_NS)

`endif

/* File: design/tht_readout.v */
// Temperature history logger with key-sector command handshake and 512-byte table readout over APB
//
// Behaviour
// - Key sector needs action 0005h, function 0001h, table id in word 2.
// - Accepted request answers error 00h, count 01h/00h, status 50h.
// - Table id 0002h is temperature history; every other id is refused.
// - Table bytes 1:0 hold format version 0002h.
// - Bytes 3:2 hold sampling period in minutes; zero disables sampling.
// - Bytes 5:4 hold the interval between queue entries.
// - Bytes 6 to 9 hold four fixed signed temperature limits, never 80h.
// - Bytes 29:10 reserved zero; bytes 31:30 report queue length 128.
// - Bytes 33:32 hold index of newest entry; entry zero at byte 34.
// - Queue bytes are signed temperatures; 80h marks a start or a gap.
// - Samples due during a command wait until the command ends.
// - History survives power cycles; each power-up appends one 80h entry. The code clears the history instead when i_hist_blank is high.
// - Clearing sets index zero, entry zero current temperature, others 80h.
// - From acceptance to completion busy or data request stays high.
// - Interrupt request raised when busy falls at command end.
// - Only a reset aborts a command; command writes while busy are ignored.
// - Status read, reset or command write clears a pending interrupt.
// - Data-in commands return one 512-byte sector to the host.
// - Data-out commands take one 512-byte sector from the host.
// - Logging interval accepts 0001h to FFFFh, rejects zero, defaults 0001h. The code also rejects any interval write made outside S_IDLE.
// - Interval change clears the queue, keeps period and limits.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "tht_map.vh"

module tht_readout #(
  parameter AW = 8,
  parameter [39:0] P_MINUTE_CYCLES = `THT_MINUTE_CYCLES,
  parameter [7:0] P_MAX_OP = 8'h3c,
  parameter [7:0] P_OVER = 8'h46,
  parameter [7:0] P_MIN_OP = 8'h05,
  parameter [7:0] P_UNDER = 8'hfb
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [AW-1:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  // Sensor and strap pins
  input wire [7:0] i_temp,
  input wire i_hist_blank,
  // Command status
  output wire o_intrq,
  output wire o_bsy,
  output wire o_drq
);

  localparam [2:0] S_PWR = 3'd0;
  localparam [2:0] S_CLR = 3'd1;
  localparam [2:0] S_IDLE = 3'd2;
  localparam [2:0] S_GAP = 3'd3;
  localparam [2:0] S_KEY = 3'd4;
  localparam [2:0] S_CHK = 3'd5;
  localparam [2:0] S_TBL = 3'd6;

  // Retained history; no reset so it outlives resets
  reg [7:0] mem [0:127];
  reg [6:0] idx_r;

  reg [2:0] state_r;
  reg [1:0] pwr_cnt_r;
  reg [6:0] clr_cnt_r;
  reg [7:0] wcnt_r;
  reg bsy_r;
  reg drq_r;
  reg err_r;
  reg intrq_r;
  reg tbl_ok_r;
  reg [7:0] cmd_r;
  reg [7:0] tf_err_r;
  reg [7:0] tf_cyl_lo_r;
  reg [7:0] tf_cyl_hi_r;
  reg [15:0] key_act_r;
  reg [15:0] key_func_r;
  reg [15:0] key_tid_r;
  reg [15:0] interval_r;
  reg [15:0] period_r;
  reg iv_bad_r;
  reg [39:0] presc_r;
  reg [15:0] ivcnt_r;
  reg sample_due_r;
  reg pready_r;
  reg pslverr_r;
  reg [31:0] prdata_r;
  reg [7:0] temp_m_r;
  reg [7:0] temp_s_r;
  reg blank_m_r;
  reg blank_s_r;
  wire [15:0] fmt_ver = `THT_FMT_VERSION;
  wire [15:0] q_len = `THT_QUEUE_LEN;

  function [6:0] inc7;
    input [6:0] v;
    begin
      inc7 = v + 7'd1;
    end
  endfunction

  function [7:0] fix_byte;
    input [8:0] b;
    begin
      case (b)
        9'd0: fix_byte = fmt_ver[7:0];
        9'd1: fix_byte = fmt_ver[15:8];
        9'd2: fix_byte = period_r[7:0];
        9'd3: fix_byte = period_r[15:8];
        9'd4: fix_byte = interval_r[7:0];
        9'd5: fix_byte = interval_r[15:8];
        9'd6: fix_byte = P_MAX_OP;
        9'd7: fix_byte = P_OVER;
        9'd8: fix_byte = P_MIN_OP;
        9'd9: fix_byte = P_UNDER;
        9'd30: fix_byte = q_len[7:0];
        9'd31: fix_byte = q_len[15:8];
        9'd32: fix_byte = {1'b0, idx_r};
        default: fix_byte = 8'h00;
      endcase
    end
  endfunction

  // Pin synchronisers; temperature moves slowly so byte-wide capture is safe enough
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      temp_m_r <= 8'h00;
      temp_s_r <= 8'h00;
      blank_m_r <= 1'b0;
      blank_s_r <= 1'b0;
    end else begin
      temp_m_r <= i_temp;
      temp_s_r <= temp_m_r;
      blank_m_r <= i_hist_blank;
      blank_s_r <= blank_m_r;
    end
  end

  // APB decode
  wire setup_acc = i_psel & i_penable & ~pready_r;
  wire acc = i_psel & i_penable & pready_r;
  wire wr_go = acc & i_pwrite;
  wire rd_go = acc & ~i_pwrite;
  wire [7:0] ofs = i_paddr[7:0];
  wire a_hi_zero = (i_paddr >> 8) == 0;
  wire sel_cmd = a_hi_zero & (ofs == `THT_OFS_CMD);
  wire sel_sts = a_hi_zero & (ofs == `THT_OFS_STATUS);
  wire sel_tf = a_hi_zero & (ofs == `THT_OFS_TASKFILE);
  wire sel_dat = a_hi_zero & (ofs == `THT_OFS_DATA);
  wire sel_ctl = a_hi_zero & (ofs == `THT_OFS_CTRL);
  wire sel_iv = a_hi_zero & (ofs == `THT_OFS_INTERVAL);
  wire sel_per = a_hi_zero & (ofs == `THT_OFS_PERIOD);
  wire sel_idx = a_hi_zero & (ofs == `THT_OFS_INDEX);
  wire hit = sel_cmd | sel_sts | sel_tf | sel_dat | sel_ctl | sel_iv | sel_per | sel_idx;

  wire cmd_wr = wr_go & sel_cmd;
  wire soft_rst = wr_go & sel_ctl & i_pwdata[0];
  wire iv_wr = wr_go & sel_iv;
  wire iv_wr_ok = iv_wr & (i_pwdata[15:0] != 16'h0000) & (state_r == S_IDLE);
  wire dat_wr = wr_go & sel_dat;
  wire dat_rd = rd_go & sel_dat;
  wire sts_rd = rd_go & sel_sts;
  wire in_cmd = (state_r == S_GAP) | (state_r == S_KEY) | (state_r == S_CHK) | (state_r == S_TBL);

  // History write events
  wire pwr_done = (state_r == S_PWR) & (pwr_cnt_r == 2'd3);
  wire clr_start = (pwr_done & blank_s_r) | iv_wr_ok;
  wire app_pwr = pwr_done & ~blank_s_r;
  wire take_smp = (state_r == S_IDLE) & sample_due_r & ~cmd_wr & ~iv_wr;
  wire clr_fill = state_r == S_CLR;

  reg mem_we;
  reg [6:0] mem_wa;
  reg [7:0] mem_wd;
  reg idx_we;
  reg [6:0] idx_wd;

  always @* begin
    mem_we = 1'b0;
    mem_wa = 7'd0;
    mem_wd = `THT_GAP_MARK;
    idx_we = 1'b0;
    idx_wd = idx_r;
    if (clr_start) begin
      mem_we = 1'b1;
      mem_wd = temp_s_r;
      idx_we = 1'b1;
      idx_wd = 7'd0;
    end else if (app_pwr) begin
      mem_we = 1'b1;
      mem_wa = inc7(idx_r);
      idx_we = 1'b1;
      idx_wd = inc7(idx_r);
    end else if (take_smp) begin
      mem_we = 1'b1;
      mem_wa = inc7(idx_r);
      mem_wd = temp_s_r;
      idx_we = 1'b1;
      idx_wd = inc7(idx_r);
    end else if (clr_fill) begin
      mem_we = 1'b1;
      mem_wa = clr_cnt_r;
    end
  end

  always @(posedge i_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    if (idx_we) begin
      idx_r <= idx_wd;
    end
  end

  // Table word at the current transfer position
  wire [8:0] bpos = {wcnt_r, 1'b0};
  wire in_q = (bpos >= `THT_QUEUE_BASE) & (bpos < `THT_QUEUE_END);
  wire [8:0] qoff = bpos - `THT_QUEUE_BASE;
  wire [6:0] qa = qoff[6:0];
  wire [6:0] qb = inc7(qoff[6:0]);
  wire [15:0] tbl_word = in_q ? {mem[qb], mem[qa]} : {fix_byte(bpos + 9'd1), fix_byte(bpos)};

  wire [7:0] sts_byte = {bsy_r, (state_r != S_PWR), 1'b0, 1'b1, drq_r, 2'b00, err_r};

  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h0000_0000;
    if (sel_sts) begin
      rd_val = {24'h00_0000, sts_byte};
    end else if (sel_tf) begin
      rd_val = {8'h00, tf_cyl_hi_r, tf_cyl_lo_r, tf_err_r};
    end else if (sel_dat) begin
      rd_val = (state_r == S_TBL) ? {16'h0000, tbl_word} : 32'h0000_0000;
    end else if (sel_ctl) begin
      rd_val = {31'h0000_0000, iv_bad_r};
    end else if (sel_iv) begin
      rd_val = {16'h0000, interval_r};
    end else if (sel_per) begin
      rd_val = {16'h0000, period_r};
    end else if (sel_idx) begin
      rd_val = {23'h00_0000, intrq_r, 1'b0, idx_r};
    end
  end

  // Bus answer: one wait state, then ready; unmapped offsets give an error
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup_acc;
      pslverr_r <= setup_acc & ~hit;
      if (setup_acc) begin
        prdata_r <= i_pwrite ? 32'h0000_0000 : rd_val;
      end
    end
  end

  // Minute prescaler and logging interval timer
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      presc_r <= 40'd0;
      ivcnt_r <= 16'h0000;
      sample_due_r <= 1'b0;
    end else begin
      if (iv_wr_ok) begin
        presc_r <= 40'd0;
        ivcnt_r <= 16'h0000;
        sample_due_r <= 1'b0;
      end else begin
        if (presc_r >= P_MINUTE_CYCLES - 40'd1) begin
          presc_r <= 40'd0;
          if (ivcnt_r + 16'h0001 >= interval_r) begin
            ivcnt_r <= 16'h0000;
            sample_due_r <= (period_r != 16'h0000) | (sample_due_r & ~take_smp);
          end else begin
            ivcnt_r <= ivcnt_r + 16'h0001;
            sample_due_r <= sample_due_r & ~take_smp;
          end
        end else begin
          presc_r <= presc_r + 40'd1;
          sample_due_r <= sample_due_r & ~take_smp;
        end
      end
    end
  end

  // Command sequencer
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= S_PWR;
      pwr_cnt_r <= 2'd0;
      clr_cnt_r <= 7'd0;
      wcnt_r <= 8'h00;
      bsy_r <= 1'b1;
      drq_r <= 1'b0;
      err_r <= 1'b0;
      intrq_r <= 1'b0;
      tbl_ok_r <= 1'b0;
      cmd_r <= 8'h00;
      tf_err_r <= 8'h00;
      tf_cyl_lo_r <= 8'h00;
      tf_cyl_hi_r <= 8'h00;
      key_act_r <= 16'h0000;
      key_func_r <= 16'h0000;
      key_tid_r <= 16'h0000;
      interval_r <= `THT_INTERVAL_RST;
      period_r <= `THT_PERIOD_RST;
      iv_bad_r <= 1'b0;
    end else begin
      if (sts_rd | cmd_wr | soft_rst) begin
        intrq_r <= 1'b0;
      end
      if (wr_go & sel_per) begin
        period_r <= i_pwdata[15:0];
      end
      if (iv_wr) begin
        iv_bad_r <= ~iv_wr_ok;
      end
      if (iv_wr_ok) begin
        interval_r <= i_pwdata[15:0];
      end
      if (soft_rst & in_cmd) begin
        state_r <= S_IDLE;
        bsy_r <= 1'b0;
        drq_r <= 1'b0;
        tbl_ok_r <= 1'b0;
      end else begin
        case (state_r)
          S_PWR: begin
            pwr_cnt_r <= pwr_cnt_r + 2'd1;
            if (pwr_done) begin
              if (blank_s_r) begin
                state_r <= S_CLR;
                clr_cnt_r <= 7'd1;
              end else begin
                state_r <= S_IDLE;
                bsy_r <= 1'b0;
              end
            end
          end
          S_CLR: begin
            clr_cnt_r <= inc7(clr_cnt_r);
            if (clr_cnt_r == 7'd127) begin
              state_r <= S_IDLE;
              bsy_r <= 1'b0;
            end
          end
          S_IDLE: begin
            if (cmd_wr) begin
              cmd_r <= i_pwdata[7:0];
              bsy_r <= 1'b1;
              err_r <= 1'b0;
              state_r <= S_GAP;
            end else if (iv_wr_ok) begin
              state_r <= S_CLR;
              bsy_r <= 1'b1;
              clr_cnt_r <= 7'd1;
            end
          end
          S_GAP: begin
            wcnt_r <= 8'h00;
            if (cmd_r == `THT_CMD_KEY_OUT) begin
              state_r <= S_KEY;
              drq_r <= 1'b1;
              bsy_r <= 1'b0;
            end else if ((cmd_r == `THT_CMD_TABLE_IN) & tbl_ok_r) begin
              state_r <= S_TBL;
              drq_r <= 1'b1;
              bsy_r <= 1'b0;
            end else begin
              state_r <= S_IDLE;
              bsy_r <= 1'b0;
              err_r <= 1'b1;
              tf_err_r <= `THT_ERR_ABORT;
              intrq_r <= 1'b1;
            end
          end
          S_KEY: begin
            if (dat_wr) begin
              wcnt_r <= wcnt_r + 8'h01;
              if (wcnt_r == 8'h00) begin
                key_act_r <= i_pwdata[15:0];
              end
              if (wcnt_r == 8'h01) begin
                key_func_r <= i_pwdata[15:0];
              end
              if (wcnt_r == 8'h02) begin
                key_tid_r <= i_pwdata[15:0];
              end
              if (wcnt_r == `THT_LAST_WORD) begin
                drq_r <= 1'b0;
                bsy_r <= 1'b1;
                state_r <= S_CHK;
              end
            end
          end
          S_CHK: begin
            state_r <= S_IDLE;
            bsy_r <= 1'b0;
            intrq_r <= 1'b1;
            if ((key_act_r == `THT_ACTION_TABLE) & (key_func_r == `THT_FUNC_READ) &
                (key_tid_r == `THT_TID_TEMP_HIST)) begin
              tbl_ok_r <= 1'b1;
              tf_err_r <= `THT_ERR_NONE;
              tf_cyl_lo_r <= `THT_XFER_LO;
              tf_cyl_hi_r <= `THT_XFER_HI;
            end else begin
              tbl_ok_r <= 1'b0;
              err_r <= 1'b1;
              tf_err_r <= `THT_ERR_ABORT;
              tf_cyl_lo_r <= 8'h00;
              tf_cyl_hi_r <= 8'h00;
            end
          end
          S_TBL: begin
            if (dat_rd) begin
              wcnt_r <= wcnt_r + 8'h01;
              if (wcnt_r == `THT_LAST_WORD) begin
                drq_r <= 1'b0;
                state_r <= S_IDLE;
                intrq_r <= 1'b1;
                tf_err_r <= `THT_ERR_NONE;
              end
            end
          end
          default: begin
            state_r <= S_IDLE;
            bsy_r <= 1'b0;
            drq_r <= 1'b0;
          end
        endcase
      end
    end
  end

  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_intrq = intrq_r;
  assign o_bsy = bsy_r;
  assign o_drq = drq_r;

endmodule // tht_readout
`default_nettype wire

/* File: dv/tht_props.sv */
// Port-level assertions for the temperature history readout
`timescale 1ns/100ps
`default_nettype none
module tht_props #(
  parameter AW = 8,
  parameter [39:0] P_MINUTE_CYCLES = 40'd20
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Sensor and status
  input wire logic [7:0] i_temp,
  input wire logic i_hist_blank,
  input wire logic o_intrq,
  input wire logic o_bsy,
  input wire logic o_drq
);
  logic cmd_act_r;
  logic done;
  logic cmd_wr;
  logic soft_wr;
  logic go;
  assign done = i_psel && i_penable && o_pready;
  assign cmd_wr = done && i_pwrite && i_paddr == 'h0;
  assign soft_wr = done && i_pwrite && i_paddr == 'h10 && i_pwdata[0];
  assign go = cmd_wr && !o_bsy && !o_drq && (i_pwdata[7:0] == 8'h3f || i_pwdata[7:0] == 8'h2f);
  // Open from an accepted command to its interrupt; a soft reset ends it with no interrupt
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cmd_act_r <= 1'b0;
    end else if (go) begin
      cmd_act_r <= 1'b1;
    end else if (soft_wr || o_intrq) begin
      cmd_act_r <= 1'b0;
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  sequence s_access;
    i_psel && !i_penable ##1 i_psel && i_penable;
  endsequence
  sequence s_cmd_start;
    (o_bsy && !o_intrq) ##1 (o_drq && !o_bsy);
  endsequence
  a_ack_wait: assert property (s_access |=> o_pready)
    else $error("pready not one cycle after access");
  a_ack_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  a_ack_access: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready outside access phase");
  a_slverr_map: assert property (done |-> o_pslverr == (i_paddr > 'h1c || i_paddr[1:0] != 2'b00))
    else $error("pslverr does not match address map");
  a_cmd_start: assert property (go |=> s_cmd_start)
    else $error("command start handshake wrong");
  a_drq_end: assert property ($fell(o_drq) && !$past(soft_wr) && !$past(soft_wr, 2) |-> o_bsy || o_intrq)
    else $error("data request fell with neither busy nor interrupt");
  a_intrq_end: assert property ($fell(o_bsy) && !o_drq && cmd_act_r |-> o_intrq)
    else $error("busy fell at command end without interrupt");
  a_status_clr: assert property (done && !i_pwrite && i_paddr == 'h4 |=> !o_intrq)
    else $error("status read left interrupt pending");
  a_busy_ignore: assert property (cmd_wr && o_drq |=> o_drq)
    else $error("command write during data phase disturbed it");
endmodule // tht_props
bind tht_readout tht_props #(.AW(AW), .P_MINUTE_CYCLES(P_MINUTE_CYCLES)) tht_props_inst (
  .i_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
  .o_pready, .o_pslverr, .i_temp, .i_hist_blank, .o_intrq, .o_bsy, .o_drq
);
`default_nettype wire

/* File: dv/tht_host.sv */
// Host model: APB master issuing key sector and table commands
`timescale 1ns/100ps
`default_nettype none
`include "tht_map.vh"
module tht_host (
  // Clock
  input wire logic i_clk,
  // APB master
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr,
  // Device status pins
  input wire logic i_bsy,
  input wire logic i_drq
);
  logic [31:0] q;
  logic e;
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
  end
  // Address and data invert on release so a stale value never looks valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq,
                      output logic re);
    int n;
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (!i_pready && n < 16);
    rq = i_prdata;
    re = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~a;
    o_pwdata <= ~d;
    if (!i_pready) tht_readout_bench.hang();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] rq, output logic re);
    xfer(1'b0, a, 32'h0, rq, re);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      rd(`THT_OFS_STATUS, q, e);
      n++;
    end while ((q[7] || !q[6] || q[3]) && n < 200);
    if (q[7] || !q[6] || q[3]) tht_readout_bench.hang();
  endtask
  task automatic cmd(input logic [7:0] c);
    wait_idle();
    wr(`THT_OFS_CMD, {24'h0, c});
  endtask
  task automatic wait_pin(input logic drq_v, input logic bsy_v);
    int n;
    n = 0;
    while ((i_drq !== drq_v || i_bsy !== bsy_v) && n < 100) begin
      @(posedge i_clk);
      n++;
    end
    if (n == 100) tht_readout_bench.hang();
  endtask
  // Whole key sector: 256 words, unused words zero
  task automatic key(input logic [15:0] act, input logic [15:0] fn, input logic [15:0] id);
    logic [15:0] w;
    cmd(`THT_CMD_KEY_OUT);
    wait_pin(1'b1, 1'b0);
    for (int k = 0; k < 256; k++) begin
      w = k == 0 ? act : k == 1 ? fn : k == 2 ? id : 16'h0000;
      wr(`THT_OFS_DATA, {16'h0, w});
    end
    wait_pin(1'b0, 1'b0);
  endtask
endmodule // tht_host
`default_nettype wire

/* File: dv/tht_readout_bench.sv */
// Self-checking bench for the temperature history readout
`timescale 1ns/100ps
`default_nettype none
`include "tht_map.vh"
module tht_readout_bench;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_intrq, o_bsy, o_drq;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, q;
  logic [7:0] i_temp = 8'h19;
  logic i_hist_blank = 1'b1;
  logic e;
  logic [7:0] mq [128];
  logic [7:0] ex [512];
  logic [15:0] bad [6] = '{16'h0000, 16'h0001, 16'h0003, 16'hd000, 16'h0002, 16'h0002};
  int miscompares = 0;
  int cmp_count = 0;
  always #5 i_clk = ~i_clk;
  // Short minute keeps the sampling tick reachable
  tht_readout #(.P_MINUTE_CYCLES(40'd20)) tht_readout_inst (
    .i_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
    .o_pslverr, .i_temp, .i_hist_blank, .o_intrq, .o_bsy, .o_drq
  );
  tht_host tht_host_inst (
    .i_clk, .o_psel(i_psel), .o_penable(i_penable), .o_pwrite(i_pwrite), .o_paddr(i_paddr),
    .o_pwdata(i_pwdata), .i_prdata(o_prdata), .i_pready(o_pready), .i_pslverr(o_pslverr),
    .i_bsy(o_bsy), .i_drq(o_drq)
  );
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic hang();
    miscompares++;
    $display("Error at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
    give_verdict();
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Pins are looked at mid-cycle, after the edge's updates have landed
  task automatic chk_pins(input logic [2:0] exp);
    @(negedge i_clk);
    chk_reg({29'h0, o_intrq, o_bsy, o_drq}, {29'h0, exp});
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    tht_host_inst.rd(a, q, e);
    chk_reg(q, exp);
  endtask
  task automatic read_table(input logic [15:0] per, input logic [15:0] ivl, input logic [6:0] idx);
    for (int b = 0; b < 512; b++) ex[b] = 8'h00;
    {ex[1], ex[0]} = `THT_FMT_VERSION;
    {ex[3], ex[2]} = per;
    {ex[5], ex[4]} = ivl;
    {ex[9], ex[8], ex[7], ex[6]} = 32'hfb05463c;
    ex[30] = 8'h80;
    ex[32] = {1'b0, idx};
    for (int j = 0; j < 128; j++) ex[34 + j] = mq[j];
    tht_host_inst.cmd(`THT_CMD_TABLE_IN);
    tht_host_inst.wait_pin(1'b1, 1'b0);
    for (int k = 0; k < 256; k++) begin
      rd_chk(`THT_OFS_DATA, {16'h0, ex[2 * k + 1], ex[2 * k]});
    end
    tht_host_inst.wait_pin(1'b0, 1'b0);
    chk_pins(3'b100);
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    tht_host_inst.wr(`THT_OFS_PERIOD, 32'h0);
    tht_host_inst.wait_idle();
    rd_chk(`THT_OFS_INDEX, 32'h0);
    rd_chk(`THT_OFS_INTERVAL, 32'h1);
    tht_host_inst.rd(8'h20, q, e);
    chk_reg({31'h0, e}, 32'h1);
    chk_reg(q, 32'h0);
    tht_host_inst.wr(`THT_OFS_INTERVAL, 32'h0);
    rd_chk(`THT_OFS_CTRL, 32'h1);
    rd_chk(`THT_OFS_INTERVAL, 32'h1);
    i_temp <= 8'he7;
    repeat (4) @(posedge i_clk);
    tht_host_inst.wr(`THT_OFS_INTERVAL, 32'h3);
    tht_host_inst.wait_idle();
    rd_chk(`THT_OFS_CTRL, 32'h0);
    rd_chk(`THT_OFS_PERIOD, 32'h0);
    rd_chk(`THT_OFS_INDEX, 32'h0);
    for (int j = 0; j < 128; j++) mq[j] = j == 0 ? 8'he7 : 8'h80;
    // One sampling tick with a new temperature, then sampling is stopped again
    i_temp <= 8'h2a;
    tht_host_inst.wr(`THT_OFS_PERIOD, 32'h1);
    for (int n = 0; n < 60 && q[6:0] !== 7'h1; n++) tht_host_inst.rd(`THT_OFS_INDEX, q, e);
    tht_host_inst.wr(`THT_OFS_PERIOD, 32'h0);
    rd_chk(`THT_OFS_INDEX, 32'h1);
    mq[1] = 8'h2a;
    for (int t = 0; t < 6; t++) begin
      tht_host_inst.key(t == 4 ? 16'h0004 : 16'h0005, t == 5 ? 16'h0002 : 16'h0001, bad[t]);
      chk_pins(3'b100);
      tht_host_inst.rd(`THT_OFS_TASKFILE, q, e);
      chk_reg(q & 32'hff, 32'h4);
      rd_chk(`THT_OFS_STATUS, 32'h51);
    end
    tht_host_inst.cmd(`THT_CMD_KEY_OUT);
    tht_host_inst.wait_pin(1'b1, 1'b0);
    tht_host_inst.wr(`THT_OFS_CMD, 32'h2f);
    chk_pins(3'b001);
    tht_host_inst.wr(`THT_OFS_CTRL, 32'h1);
    tht_host_inst.wait_pin(1'b0, 1'b0);
    tht_host_inst.key(16'h0005, 16'h0001, `THT_TID_TEMP_HIST);
    chk_pins(3'b100);
    rd_chk(`THT_OFS_TASKFILE, 32'h100);
    rd_chk(`THT_OFS_STATUS, 32'h50);
    chk_pins(3'b000);
    read_table(16'h0, 16'h3, 7'h1);
    // Power cycle without the blank strap keeps the history and appends a gap mark
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    i_hist_blank <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    tht_host_inst.wr(`THT_OFS_PERIOD, 32'h0);
    tht_host_inst.wait_idle();
    rd_chk(`THT_OFS_INDEX, 32'h2);
    // Reset forgets the accepted key, so the table needs a fresh one
    tht_host_inst.key(16'h0005, 16'h0001, `THT_TID_TEMP_HIST);
    read_table(16'h0, 16'h1, 7'h2);
    give_verdict();
  end
endmodule // tht_readout_bench
`default_nettype wire
